// [logic/idc_pkg.sv]
// Purpose: Shared constants and types for the four-channel DMA controller
// Assumes: Byte-wide I/O port, one system clock
// Notes:   Offsets are port addresses within the controller's 32-port window
package idc_pkg;

  // ******************************
  // Port map
  // ******************************
  localparam logic [4:0] ADDR_CMD      = 5'h08; // Command, read and write
  localparam logic [4:0] ADDR_REQ      = 5'h09; // Software request
  localparam logic [4:0] ADDR_MASK1    = 5'h0a; // Single mask bit write
  localparam logic [4:0] ADDR_MODE     = 5'h0b; // Four mode registers
  localparam logic [4:0] ADDR_CLR_PTR  = 5'h0c; // Clear byte pointer
  localparam logic [4:0] ADDR_MCLR     = 5'h0d; // Master clear
  localparam logic [4:0] ADDR_CLR_MASK = 5'h0e; // Clear all mask bits
  localparam logic [4:0] ADDR_STATUS   = 5'h10; // Status, read
  localparam logic [4:0] ADDR_SET_PTR  = 5'h11; // Set byte pointer
  localparam logic [4:0] ADDR_CLR_MCNT = 5'h12; // Clear mode read counter
  localparam logic [4:0] ADDR_WCNT0    = 5'h01; // Channel 0 word count
  localparam logic [4:0] ADDR_CHAN_TOP = 5'h07; // Last address/count port

  // ******************************
  // Fields and reset values
  // ******************************
  localparam int CMD_DIS      = 2;
  localparam int CMD_ROT      = 4;
  localparam int CMD_EXTW     = 5;
  localparam int CMD_DRQ_LO   = 6;
  localparam int CMD_DACK_HI  = 7;
  localparam logic [7:0] CMD_USED_MASK = 8'hf4;
  localparam logic [7:0] CMD_RST       = 8'h00;
  localparam logic [3:0] MASK_RST      = 4'hf;
  localparam logic [5:0] MODE_RST      = 6'h00;
  localparam int MODE_XFER_LSB  = 2;
  localparam int MODE_AUTO      = 4;
  localparam int MODE_DIR       = 5;
  localparam int MODE_STYLE_LSB = 6;
  localparam int REQ_VAL        = 2;

  typedef enum logic [1:0] {
    XT_VERIFY = 2'h0,
    XT_WRITE  = 2'h1,
    XT_READ   = 2'h2,
    XT_UNUSED = 2'h3
  } idc_xfer_type;

  typedef enum logic [1:0] {
    SS_DEMAND  = 2'h0,
    SS_SINGLE  = 2'h1,
    SS_BLOCK   = 2'h2,
    SS_CASCADE = 2'h3
  } idc_style_type;

  // Gray along idle, S1, S2, S3, S4; cascade hold off the path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_S1   = 3'h1,
    ST_S2   = 3'h3,
    ST_S3   = 3'h2,
    ST_S4   = 3'h6,
    ST_CASC = 3'h4
  } idc_state_type;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } idc_io_req_type;

  typedef struct packed {
    logic mem_rd;
    logic mem_wr;
    logic dev_rd;
    logic dev_wr;
  } idc_strobe_type;

endpackage

// [logic/idc_dma_ctrl.sv]
// Purpose: Four-channel DMA controller, registers and transfer sequencer
// Assumes: I/O strobes are one-cycle pulses on clk_sys_i; request pins async
// Notes:   Single cycle, block, demand and cascade service styles
//
// Operation
// RQ1 - Each channel transfers count plus one words, decrementing until wrap to all ones.
// RQ2 - On wrap pulse terminal count, then mask channel, or reload when auto-init.
// RQ3 - Writing current word count also loads base count, restored on auto-init.
// RQ4 - Address steps once per transfer, reloaded from base address on auto-init.
// RQ5 - Command register is read/write, cleared by reset or master clear.
// RQ6 - Command bit 2 disables the controller; no new cycles start.
// RQ7 - Command bit 4 selects rotating priority, otherwise fixed priority.
// RQ8 - Command bit 5 starts the write strobe early, in S2 with read.
// RQ9 - Bit 6 makes requests active low; bit 7 makes acknowledges active high.
// RQ10 - Mode registers share one port; bits 1:0 pick the channel.
// RQ11 - Mode reads return channels 0 to 3 in turn via a clearable counter.
// RQ12 - Mode bits 3:2 pick verify, write or read transfers.
// RQ13 - Mode bit 4 enables auto-initialization.
// RQ14 - Mode bits 7:6 pick demand, single, block or cascade service.
// RQ15 - Software requests bypass the mask; reset clears them all.
// RQ16 - Request write: bits 1:0 pick channel, bit 2 gives the value.
// RQ17 - Status bits 3:0 flag terminal count; cleared by reset or status read.
// RQ18 - Status bits 7:4 show raw external requests, cleared when they drop.
// RQ19 - Special commands fire on read or write; data is ignored.
// RQ20 - Clear or set byte pointer aims next access at low or high byte.
// RQ21 - Byte pointer toggles after each address or count byte access.
// RQ22 - Master clear resets like hardware reset and sets all mask bits; channel, mode and priority registers keep their values.
// RQ23 - Clear-mask command clears all four mask bits.
// RQ24 - Host disables the controller before reprogramming channels.
`timescale 1ns/1ns
module idc_dma_ctrl (
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  input  wire idc_pkg::idc_io_req_type io_req_i,
  output logic [7:0]                   io_rdata_o,
  input  wire logic [3:0]              drq_pin_i,
  output logic [3:0]                   dack_o,
  output logic                         tc_o,
  output logic [15:0]                  xfer_addr_o,
  output idc_pkg::idc_strobe_type      strobe_o
);

  // ******************************
  // Storage
  // ******************************
  logic [15:0]            cur_addr_r [4];
  logic [15:0]            base_addr_r [4];
  logic [15:0]            cur_cnt_r [4];
  logic [15:0]            base_cnt_r [4];
  logic [5:0]             mode_r [4];
  logic [7:0]             cmd_r;
  logic [3:0]             mask_r;
  logic [3:0]             sw_req_r;
  logic [3:0]             tc_flag_r;
  logic                   ptr_hi_r;
  logic [1:0]             mode_cnt_r;
  logic [1:0]             chan_r;
  logic [1:0]             last_r;
  logic [7:0]             rdata_r;
  logic [3:0]             drq_meta_r;
  logic [3:0]             drq_sync_r;
  idc_pkg::idc_state_type state_r;
  idc_pkg::idc_state_type state_nxt;

  // ******************************
  // Bus decode
  // ******************************
  wire       acc        = io_req_i.rd | io_req_i.wr;
  wire [4:0] a          = io_req_i.addr;
  wire [7:0] wd         = io_req_i.wdata;
  wire       chan_acc   = acc & (a <= idc_pkg::ADDR_CHAN_TOP);
  wire       is_cnt     = a[0];
  wire [1:0] acc_ch     = a[2:1];
  wire       wr_chan    = io_req_i.wr & chan_acc;
  wire       wr_cmd     = io_req_i.wr & (a == idc_pkg::ADDR_CMD);
  wire       wr_req     = io_req_i.wr & (a == idc_pkg::ADDR_REQ);
  wire       wr_mask1   = io_req_i.wr & (a == idc_pkg::ADDR_MASK1);
  wire       wr_mode    = io_req_i.wr & (a == idc_pkg::ADDR_MODE);
  wire       rd_mode    = io_req_i.rd & (a == idc_pkg::ADDR_MODE);
  wire       rd_status  = io_req_i.rd & (a == idc_pkg::ADDR_STATUS);
  // Special commands react to either strobe, data unused
  wire       cmd_clrptr = acc & (a == idc_pkg::ADDR_CLR_PTR);  // RQ19
  wire       cmd_setptr = acc & (a == idc_pkg::ADDR_SET_PTR);  // RQ19
  wire       cmd_mclr   = acc & (a == idc_pkg::ADDR_MCLR);     // RQ19
  wire       cmd_clrmsk = acc & (a == idc_pkg::ADDR_CLR_MASK); // RQ19
  wire       cmd_clrmcn = acc & (a == idc_pkg::ADDR_CLR_MCNT); // RQ19

  // Write fields of a mode byte
  wire       mode_chan_sel_hi = wd[1];
  wire       mode_chan_sel_lo = wd[0];
  wire [1:0] mode_chan        = {mode_chan_sel_hi, mode_chan_sel_lo}; // RQ10

  // Fields of the active channel's mode
  wire [5:0] act_mode         = mode_r[chan_r];
  wire       xfer_type_hi     = act_mode[idc_pkg::MODE_XFER_LSB - 1];
  wire       xfer_type_lo     = act_mode[idc_pkg::MODE_XFER_LSB - 2];
  wire       service_style_hi = act_mode[idc_pkg::MODE_STYLE_LSB - 1];
  wire       service_style_lo = act_mode[idc_pkg::MODE_STYLE_LSB - 2];
  wire       act_auto         = act_mode[idc_pkg::MODE_AUTO - 2];
  wire       act_dec          = act_mode[idc_pkg::MODE_DIR - 2];
  wire idc_pkg::idc_xfer_type  act_xt = idc_pkg::idc_xfer_type'({xfer_type_hi, xfer_type_lo});    // RQ12
  wire idc_pkg::idc_style_type act_ss = idc_pkg::idc_style_type'({service_style_hi, service_style_lo}); // RQ14

  // ******************************
  // Requests and arbitration
  // ******************************
  // Polarity applied after the synchroniser, never to the first stage
  wire [3:0] ext_req  = cmd_r[idc_pkg::CMD_DRQ_LO] ? ~drq_sync_r : drq_sync_r; // RQ9
  wire [3:0] eff_req  = (ext_req & ~mask_r) | sw_req_r;                        // RQ15
  wire [1:0] prio_lo  = cmd_r[idc_pkg::CMD_ROT] ? 2'(last_r + 2'h1) : 2'h0;    // RQ7
  wire       dis      = cmd_r[idc_pkg::CMD_DIS];
  wire       act_req  = eff_req[chan_r];
  wire       last_xfr = (cur_cnt_r[chan_r] == 16'h0000);                       // RQ1
  wire       tc_now   = (state_r == idc_pkg::ST_S4) & last_xfr;

  logic [1:0] win_ch;
  logic       win_any;

  // Scan down from the lowest-priority channel to the base; last asserted wins
  always_comb begin
    logic [1:0] idx;
    idx     = 2'h0;
    win_ch  = 2'h0;
    win_any = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      idx = 2'(prio_lo + 2'(i));
      if (eff_req[idx]) begin
        win_ch  = idx;
        win_any = 1'b1;
      end
    end
  end

  // ******************************
  // Sequencer
  // ******************************
  // Next state; disable only gates new starts and block or demand continuation
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      idc_pkg::ST_IDLE: begin
        if (!dis && win_any) begin // RQ6
          state_nxt = idc_pkg::ST_S1;
        end
      end
      idc_pkg::ST_S1: begin
        if (act_ss == idc_pkg::SS_CASCADE) begin // RQ14
          state_nxt = idc_pkg::ST_CASC;
        end else begin
          state_nxt = idc_pkg::ST_S2;
        end
      end
      idc_pkg::ST_S2:   state_nxt = idc_pkg::ST_S3;
      idc_pkg::ST_S3:   state_nxt = idc_pkg::ST_S4;
      idc_pkg::ST_S4: begin
        state_nxt = idc_pkg::ST_IDLE;
        if (!dis && !last_xfr) begin
          if (act_ss == idc_pkg::SS_BLOCK) begin // RQ14
            state_nxt = idc_pkg::ST_S1;
          end else if (act_ss == idc_pkg::SS_DEMAND && act_req) begin // RQ14
            state_nxt = idc_pkg::ST_S1;
          end
        end
      end
      idc_pkg::ST_CASC: begin
        if (!act_req) begin
          state_nxt = idc_pkg::ST_IDLE;
        end
      end
      default: state_nxt = idc_pkg::ST_IDLE;
    endcase
  end

  // State, grant and synchroniser
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r    <= idc_pkg::ST_IDLE;
      chan_r     <= 2'h0;
      last_r     <= 2'h3;
      drq_meta_r <= 4'h0;
      drq_sync_r <= 4'h0;
    end else if (ce_i) begin
      drq_meta_r <= drq_pin_i;
      drq_sync_r <= drq_meta_r;
      // Master clear drops any cycle in progress and idles
      state_r    <= cmd_mclr ? idc_pkg::ST_IDLE : state_nxt; // RQ22
      if (state_r == idc_pkg::ST_IDLE && state_nxt == idc_pkg::ST_S1) begin
        chan_r <= win_ch;
        last_r <= win_ch; // RQ7
      end
    end
  end

  // ******************************
  // Channel registers
  // ******************************
  // CPU writes load byte halves; sequencer steps at S4
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int c = 0; c < 4; c++) begin
        cur_addr_r[c]  <= 16'h0000;
        base_addr_r[c] <= 16'h0000;
        cur_cnt_r[c]   <= 16'h0000;
        base_cnt_r[c]  <= 16'h0000;
        mode_r[c]      <= idc_pkg::MODE_RST;
      end
    end else if (ce_i) begin
      if (state_r == idc_pkg::ST_S4) begin
        if (last_xfr && act_auto) begin // RQ13
          cur_addr_r[chan_r] <= base_addr_r[chan_r]; // RQ4
          cur_cnt_r[chan_r]  <= base_cnt_r[chan_r];  // RQ3
        end else begin
          cur_cnt_r[chan_r]  <= cur_cnt_r[chan_r] - 16'h0001; // RQ1
          cur_addr_r[chan_r] <= act_dec ? cur_addr_r[chan_r] - 16'h0001
                                        : cur_addr_r[chan_r] + 16'h0001; // RQ4
        end
      end
      if (wr_chan && is_cnt) begin
        if (ptr_hi_r) begin
          cur_cnt_r[acc_ch][15:8]  <= wd;
          base_cnt_r[acc_ch][15:8] <= wd; // RQ3
        end else begin
          cur_cnt_r[acc_ch][7:0]   <= wd;
          base_cnt_r[acc_ch][7:0]  <= wd; // RQ3
        end
      end
      if (wr_chan && !is_cnt) begin
        if (ptr_hi_r) begin
          cur_addr_r[acc_ch][15:8]  <= wd;
          base_addr_r[acc_ch][15:8] <= wd;
        end else begin
          cur_addr_r[acc_ch][7:0]   <= wd;
          base_addr_r[acc_ch][7:0]  <= wd;
        end
      end
      if (wr_mode) begin
        mode_r[mode_chan] <= wd[7:2]; // RQ10
      end
    end
  end

  // ******************************
  // Control and status registers
  // ******************************
  // Master clear mirrors reset for everything it names
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cmd_r      <= idc_pkg::CMD_RST;
      mask_r     <= idc_pkg::MASK_RST;
      sw_req_r   <= 4'h0;
      tc_flag_r  <= 4'h0;
      ptr_hi_r   <= 1'b0;
      mode_cnt_r <= 2'h0;
    end else if (ce_i) begin
      if (cmd_mclr) begin
        cmd_r      <= idc_pkg::CMD_RST;  // RQ22 RQ5
        mask_r     <= idc_pkg::MASK_RST; // RQ22
        sw_req_r   <= 4'h0;              // RQ22
        tc_flag_r  <= 4'h0;              // RQ22 RQ17
        ptr_hi_r   <= 1'b0;              // RQ22
        mode_cnt_r <= 2'h0;              // RQ22
      end else begin
        if (wr_cmd) begin
          cmd_r <= wd & idc_pkg::CMD_USED_MASK; // RQ5
        end
        // Clear-mask first so a terminal count in the same cycle still masks
        if (cmd_clrmsk) begin
          mask_r <= 4'h0; // RQ23
        end
        if (wr_mask1) begin
          mask_r[wd[1:0]] <= wd[idc_pkg::REQ_VAL];
        end
        if (tc_now && !act_auto) begin
          mask_r[chan_r] <= 1'b1; // RQ2
        end
        if (wr_req) begin
          sw_req_r[wd[1:0]] <= wd[idc_pkg::REQ_VAL]; // RQ16
        end
        if (tc_now) begin
          sw_req_r[chan_r] <= 1'b0;
        end
        // A terminal count in the read cycle survives the read clear
        if (rd_status) begin
          tc_flag_r <= 4'h0; // RQ17
        end
        if (tc_now) begin
          tc_flag_r[chan_r] <= 1'b1; // RQ17
        end
        if (cmd_clrptr) begin
          ptr_hi_r <= 1'b0; // RQ20
        end else if (cmd_setptr) begin
          ptr_hi_r <= 1'b1; // RQ20
        end else if (chan_acc) begin
          ptr_hi_r <= ~ptr_hi_r; // RQ21
        end
        if (cmd_clrmcn) begin
          mode_cnt_r <= 2'h0; // RQ11
        end else if (rd_mode) begin
          mode_cnt_r <= 2'(mode_cnt_r + 2'h1); // RQ11
        end
      end
    end
  end

  // ******************************
  // Read data
  // ******************************
  wire [15:0] rd_word   = is_cnt ? cur_cnt_r[acc_ch] : cur_addr_r[acc_ch];
  wire [7:0]  rd_chan   = ptr_hi_r ? rd_word[15:8] : rd_word[7:0];
  wire [7:0]  rd_modeb  = {mode_r[mode_cnt_r], mode_cnt_r}; // RQ11
  wire [7:0]  rd_stat   = {ext_req, tc_flag_r};             // RQ18 RQ17
  wire [7:0]  rd_sel    = chan_acc ? rd_chan :
                          (a == idc_pkg::ADDR_CMD)    ? cmd_r :
                          (a == idc_pkg::ADDR_REQ)    ? {4'h0, sw_req_r} :
                          (a == idc_pkg::ADDR_MODE)   ? rd_modeb :
                          (a == idc_pkg::ADDR_STATUS) ? rd_stat : 8'h00;

  // Read data held until the next read
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
    end else if (ce_i && io_req_i.rd) begin
      rdata_r <= rd_sel;
    end
  end

  // ******************************
  // Outputs
  // ******************************
  // Acknowledge covers S1..S4 and the cascade hold
  wire       busy     = (state_r != idc_pkg::ST_IDLE);
  wire [3:0] dack_act = busy ? (4'h1 << chan_r) : 4'h0;
  wire       in_s2    = (state_r == idc_pkg::ST_S2);
  wire       in_s3    = (state_r == idc_pkg::ST_S3);
  wire       rd_win   = in_s2 | in_s3;
  wire       wr_win   = in_s3 | (in_s2 & cmd_r[idc_pkg::CMD_EXTW]); // RQ8

  assign dack_o           = cmd_r[idc_pkg::CMD_DACK_HI] ? dack_act : ~dack_act; // RQ9
  assign tc_o             = tc_now; // RQ2
  assign xfer_addr_o      = cur_addr_r[chan_r];
  assign io_rdata_o       = rdata_r;
  assign strobe_o.mem_rd  = rd_win & (act_xt == idc_pkg::XT_READ);
  assign strobe_o.dev_wr  = wr_win & (act_xt == idc_pkg::XT_READ);
  assign strobe_o.dev_rd  = rd_win & (act_xt == idc_pkg::XT_WRITE);
  assign strobe_o.mem_wr  = wr_win & (act_xt == idc_pkg::XT_WRITE);

endmodule // idc_dma_ctrl

// [tb/idc_dma_chk.sv]
// Purpose: Port checks for the DMA controller
// Assumes: ce_i held high
// Notes:   Shadows the command byte to know the acknowledge polarity
`timescale 1ns/1ns
module idc_dma_chk (
  input wire logic                    clk_sys_i,
  input wire logic                    rst_i,
  input wire logic                    ce_i,
  input wire idc_pkg::idc_io_req_type io_req_i,
  input wire logic [7:0]              io_rdata_o,
  input wire logic [3:0]              drq_pin_i,
  input wire logic [3:0]              dack_o,
  input wire logic                    tc_o,
  input wire logic [15:0]             xfer_addr_o,
  input wire idc_pkg::idc_strobe_type strobe_o
);
  // ******************************
  // Command shadow
  // ******************************
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  logic       cmd_hit;
  logic       mclr_hit;
  logic [3:0] dack_idle;
  // Master clear fires on read or write alike
  assign cmd_hit   = ce_i && io_req_i.wr && (io_req_i.addr == idc_pkg::ADDR_CMD);
  assign mclr_hit  = ce_i && (io_req_i.rd || io_req_i.wr) && (io_req_i.addr == idc_pkg::ADDR_MCLR);
  assign cmd_nxt   = mclr_hit ? 8'h00 : (cmd_hit ? io_req_i.wdata : cmd_r);
  assign dack_idle = cmd_r[7] ? 4'h0 : 4'hf;
  // Shadow keeps the unmasked write byte; it matches the design's register only in bits 7:4 and 2
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cmd_r <= 8'h00;
    end else begin
      cmd_r <= cmd_nxt;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_stat_rd;
    io_req_i.rd && (io_req_i.addr == idc_pkg::ADDR_STATUS);
  endsequence
  sequence s_rd_window;
    (strobe_o.mem_wr == cmd_r[5]) ##1 (strobe_o.dev_rd && strobe_o.mem_wr) ##1 !strobe_o.dev_rd;
  endsequence
  a_reset_idle: assert property ($fell(rst_i) |-> (dack_o == 4'hf) && !tc_o && (strobe_o == 4'h0))
    else $error("outputs not idle after reset");
  a_strobe_with_ack: assert property ((strobe_o != 4'h0) |-> (dack_o != dack_idle))
    else $error("strobe without acknowledge");
  a_tc_single: assert property (tc_o |-> (strobe_o == 4'h0) ##1 !tc_o)
    else $error("terminal count not a lone pulse");
  a_disabled_quiet: assert property (cmd_r[2] && (dack_o == dack_idle) |=> (dack_o == dack_idle))
    else $error("cycle started while disabled");
  a_ext_write: assert property ($rose(strobe_o.dev_rd) |-> s_rd_window)
    else $error("write strobe timing wrong");
  a_type_pairs: assert property (strobe_o.dev_rd |-> !strobe_o.mem_rd && !strobe_o.dev_wr)
    else $error("strobe pair wrong");
  a_status_clear: assert property ((s_stat_rd ##0 (dack_o == dack_idle)) ##1 s_stat_rd |=> (io_rdata_o[3:0] == 4'h0))
    else $error("status count bits not cleared by read");
  a_cmd_back: assert property (cmd_hit ##1 (io_req_i.rd && (io_req_i.addr == idc_pkg::ADDR_CMD))
    |=> (io_rdata_o == ($past(io_req_i.wdata, 2) & idc_pkg::CMD_USED_MASK)))
    else $error("command readback wrong");
endmodule // idc_dma_chk

bind idc_dma_ctrl idc_dma_chk u_chk (
  .clk_sys_i   (clk_sys_i),
  .rst_i       (rst_i),
  .ce_i        (ce_i),
  .io_req_i    (io_req_i),
  .io_rdata_o  (io_rdata_o),
  .drq_pin_i   (drq_pin_i),
  .dack_o      (dack_o),
  .tc_o        (tc_o),
  .xfer_addr_o (xfer_addr_o),
  .strobe_o    (strobe_o)
);

// [tb/idc_periph_model.sv]
// Purpose: Peripheral on one request line of the DMA controller
// Assumes: It counts transfers by the first strobe of each bus cycle
// Notes:   Request falls early in the last cycle so no extra cycle starts
`timescale 1ns/1ns
module idc_periph_model (
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_i,
  input  wire logic                    go_i,
  input  wire logic                    act_low_i,
  input  wire logic [7:0]              limit_i,
  input  wire idc_pkg::idc_strobe_type strobe_i,
  output logic                         drq_o
);
  // ******************************
  // Request line
  // ******************************
  logic [7:0] seen_r;
  logic       busy_r;
  logic       want;
  // Line always driven, at the inactive level when idle
  assign want  = go_i && (seen_r < limit_i);
  assign drq_o = want ^ act_low_i;
  // Count strobe rises; dropping at the first beats the sync
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !go_i) begin
      seen_r <= 8'h00;
    end else if ((strobe_i != 4'h0) && !busy_r) begin
      seen_r <= seen_r + 8'h01;
    end
    busy_r <= (strobe_i != 4'h0);
  end
endmodule // idc_periph_model

// [tb/isa_dma_channel_controller_bench.sv]
// Purpose: Self-checking bench for the DMA controller
// Assumes: One peripheral on channel 2, software requests elsewhere
// Notes:   Seeded random addresses, counts and modes
`timescale 1ns/1ns
module isa_dma_channel_controller_bench;
  logic                    clk_sys_i;
  logic                    rst_i;
  logic                    ce_i;
  idc_pkg::idc_io_req_type io_req;
  logic [7:0]              io_rdata;
  logic [3:0]              dack;
  logic                    tc;
  logic [15:0]             xfer_addr;
  idc_pkg::idc_strobe_type strobe;
  logic                    go;
  logic                    act_low;
  logic [7:0]              limit;
  logic                    drq2;
  logic                    prev_any;
  logic [15:0]             last_addr;
  logic [15:0]             a16;
  logic [7:0]              v8;
  logic [5:0]              md [4];
  int                      bad_count;
  int                      compares;
  int                      n_xfer;
  int                      n_tc;
  int                      n;
  idc_dma_ctrl uut (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .io_req_i    (io_req),
    .io_rdata_o  (io_rdata),
    .drq_pin_i   ({act_low, drq2, act_low, act_low}),
    .dack_o      (dack),
    .tc_o        (tc),
    .xfer_addr_o (xfer_addr),
    .strobe_o    (strobe)
  );
  idc_periph_model u_periph (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .go_i      (go),
    .act_low_i (act_low),
    .limit_i   (limit),
    .strobe_i  (strobe),
    .drq_o     (drq2)
  );
  // ******************************
  // Clock, monitor and helpers
  // ******************************
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // Falling edge keeps clear of the launching edge
  always @(negedge clk_sys_i) begin
    if ((strobe != 4'h0) && !prev_any) begin
      n_xfer++;
      last_addr = xfer_addr;
    end
    if (tc === 1'b1) begin
      n_tc++;
    end
    prev_any = (strobe != 4'h0);
  end
  function automatic logic [7:0] mode_rb(input logic [5:0] m, input logic [1:0] c);
    return {m, c};
  endfunction
  function automatic int xfers(input int cnt);
    return cnt + 1;
  endfunction
  task automatic io_op(input logic r, input logic w, input logic [4:0] a, input logic [7:0] d);
    io_req = '{r, w, a, d};
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic idle(input int k);
    io_req = '0;
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    io_op(1'b0, 1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e, input string m);
    io_op(1'b1, 1'b0, a, 8'h00);
    chk({8'h00, io_rdata}, {8'h00, e}, m);
  endtask
  task automatic wr16(input logic [4:0] a, input logic [15:0] v);
    wr(idc_pkg::ADDR_CLR_PTR, 8'($urandom));
    wr(a, v[7:0]);
    wr(a, v[15:8]);
  endtask
  // Pointer cleared by a read strobe
  task automatic rd16(input logic [4:0] a, input logic [15:0] e, input string m);
    logic [7:0] lo;
    io_op(1'b1, 1'b0, idc_pkg::ADDR_CLR_PTR, 8'h00);
    io_op(1'b1, 1'b0, a, 8'h00);
    lo = io_rdata;
    io_op(1'b1, 1'b0, a, 8'h00);
    chk({io_rdata, lo}, e, m);
  endtask
  task automatic wait_tc(input int k);
    io_req = '0;
    for (int i = 0; i < 2000; i++) begin
      if (n_tc >= k) break;
      @(posedge clk_sys_i);
    end
    #1;
    chk(16'(n_tc >= k), 16'h0001, "terminal count wait");
  endtask
  task automatic results();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if ((bad_count == 0) && (compares > 0)) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Tests need a few hundred cycles; wide margin
  initial begin
    #200000;
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    results();
  end
  // ******************************
  // Test sequence
  // ******************************
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    io_req = '0;
    {go, act_low, limit, prev_any} = '0;
    {bad_count, compares, n_xfer, n_tc} = '0;
    n = $urandom(43941);
    repeat (5) @(posedge clk_sys_i);
    #1 rst_i = 1'b0;
    rd_chk(idc_pkg::ADDR_CMD, 8'h00, "cmd reset");
    rd_chk(idc_pkg::ADDR_REQ, 8'h00, "req reset");
    rd_chk(idc_pkg::ADDR_STATUS, 8'h00, "status reset");
    for (int i = 0; i < 4; i++) begin
      rd_chk(idc_pkg::ADDR_MODE, mode_rb(6'h00, i[1:0]), "mode reset");
    end
    $display("test reset done");
    v8 = 8'($urandom) | 8'h04;
    wr(idc_pkg::ADDR_CMD, v8);
    rd_chk(idc_pkg::ADDR_CMD, v8 & idc_pkg::CMD_USED_MASK, "cmd readback");
    io_op(1'b1, 1'b0, idc_pkg::ADDR_MCLR, 8'h00);
    rd_chk(idc_pkg::ADDR_CMD, 8'h00, "cmd after clear");
    $display("test command done");
    // Every style and each legal transfer type, one per channel
    for (int i = 0; i < 4; i++) begin
      md[i] = {i[1:0], 2'($urandom), 2'(i % 3)};
      wr(idc_pkg::ADDR_MODE, mode_rb(md[i], i[1:0]));
    end
    wr(idc_pkg::ADDR_CLR_MCNT, 8'($urandom));
    for (int i = 0; i < 4; i++) begin
      rd_chk(idc_pkg::ADDR_MODE, mode_rb(md[i], i[1:0]), "mode readback");
    end
    $display("test mode done");
    a16 = 16'($urandom);
    wr16(idc_pkg::ADDR_WCNT0, a16);
    rd16(idc_pkg::ADDR_WCNT0, a16, "count bytes");
    wr(idc_pkg::ADDR_SET_PTR, 8'h00);
    rd_chk(idc_pkg::ADDR_WCNT0, a16[15:8], "high byte first");
    rd_chk(idc_pkg::ADDR_WCNT0, a16[7:0], "pointer wraps");
    $display("test pointer done");
    // Software request on masked channel 1, single cycle, write type
    n = $urandom_range(3, 1);
    wr(idc_pkg::ADDR_CMD, 8'h04);
    wr16(5'h02, a16);
    wr16(5'h03, 16'(n));
    wr(idc_pkg::ADDR_MODE, 8'h45);
    wr(idc_pkg::ADDR_REQ, 8'h05);
    rd_chk(idc_pkg::ADDR_REQ, 8'h02, "sw req set");
    {n_xfer, n_tc} = '0;
    idle(8);
    chk(16'(n_xfer), 16'h0000, "ran while disabled");
    wr(idc_pkg::ADDR_CMD, {2'h0, 1'($urandom), 5'h00});
    wait_tc(1);
    idle(4);
    chk(16'(n_xfer), 16'(xfers(n)), "single transfers");
    chk(last_addr, a16 + 16'(n), "last address");
    rd16(5'h03, 16'hffff, "count wrapped");
    rd16(5'h02, a16 + 16'(n) + 16'h0001, "address stepped");
    rd_chk(idc_pkg::ADDR_STATUS, 8'h02, "tc flag");
    rd_chk(idc_pkg::ADDR_STATUS, 8'h00, "tc flag cleared");
    $display("test single done");
    // External request on channel 2, block, auto-init, decrement, flipped polarity
    n = $urandom_range(2, 1);
    wr(idc_pkg::ADDR_CMD, 8'hc4);
    act_low = 1'b1;
    wr16(5'h04, a16);
    wr16(5'h05, 16'(n));
    wr(idc_pkg::ADDR_MODE, 8'hba);
    wr(idc_pkg::ADDR_CLR_MASK, 8'($urandom));
    limit = 8'(2 * xfers(n));
    go = 1'b1;
    {n_xfer, n_tc} = '0;
    idle(4);
    rd_chk(idc_pkg::ADDR_STATUS, 8'h40, "ext req seen");
    wr(idc_pkg::ADDR_CMD, 8'hc0);
    wait_tc(2);
    idle(8);
    chk(16'(n_xfer), 16'(2 * xfers(n)), "auto-init rounds");
    chk(last_addr, a16 - 16'(n), "decrement address");
    rd16(5'h05, 16'(n), "count reloaded");
    rd16(5'h04, a16, "address reloaded");
    rd_chk(idc_pkg::ADDR_STATUS, 8'h04, "req gone tc set");
    $display("test block done");
    // After master clear every mask is set, so the request waits
    go = 1'b0;
    wr(idc_pkg::ADDR_MCLR, 8'($urandom));
    act_low = 1'b0;
    go = 1'b1;
    n_xfer = 0;
    idle(10);
    chk(16'(n_xfer), 16'h0000, "masked after clear");
    rd_chk(idc_pkg::ADDR_STATUS, 8'h40, "req seen though masked");
    go = 1'b0;
    $display("test clear done");
    results();
  end
endmodule // isa_dma_channel_controller_bench
